// >>> ram_fabric_controller.sv
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module ram_fabric_controller (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	block_ram_if.fabric link
);

	// ---------------------------------------------
	// bus slave
	// ---------------------------------------------

	logic ph_valid_ff;
	logic ph_write_ff;
	logic [7:0] ph_addr_ff;
	logic hreadyout_ff;
	logic [31:0] hrdata_ff;
	logic ram_reset_n_ff;
	logic take;
	logic commit;
	logic read_fill;
	logic [31:0] read_mux;

	// hsize is ignored: only whole-word transfers are supported
	assign take = hsel & htrans[1] & hready;
	assign commit = ph_valid_ff & ph_write_ff;
	assign read_fill = ph_valid_ff & ~ph_write_ff & ~hreadyout_ff;

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid_ff <= 1'b0;
			ph_write_ff <= 1'b0;
			ph_addr_ff <= 8'h00;
		end else if (take) begin
			ph_valid_ff <= 1'b1;
			ph_write_ff <= hwrite;
			ph_addr_ff <= haddr[7:0];
		end else if (hready) begin
			ph_valid_ff <= 1'b0;
		end
	end

	// reads take one wait state so that read data reflects a port edge
	// issued by the write just before
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= 1'b1;
			hrdata_ff <= block_ram_pkg::RDATA_RESET;
		end else if (take & ~hwrite) begin
			hreadyout_ff <= 1'b0;
		end else if (read_fill) begin
			hreadyout_ff <= 1'b1;
			hrdata_ff <= read_mux;
		end
	end

	// ram reset request; a set bit holds the ram in reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ram_reset_n_ff <= 1'b1;
		end else if (commit & (ph_addr_ff == block_ram_pkg::REG_CTRL)) begin
			ram_reset_n_ff <= ~hwdata[block_ram_pkg::CTRL_RST_BIT];
		end
	end

	// ---------------------------------------------
	// per-port drive
	// ---------------------------------------------

	logic [1:0] aspect_ff [block_ram_pkg::NPORTS];
	logic pipe_ff [block_ram_pkg::NPORTS];
	logic wmode_ff [block_ram_pkg::NPORTS];
	logic en_n_ff [block_ram_pkg::NPORTS];
	logic write_n_ff [block_ram_pkg::NPORTS];
	logic pulse_ff [block_ram_pkg::NPORTS];
	logic [11:0] loc_ff [block_ram_pkg::NPORTS];
	logic [8:0] wdat_ff [block_ram_pkg::NPORTS];
	logic [31:0] cfg_view [block_ram_pkg::NPORTS];
	logic [31:0] acc_view [block_ram_pkg::NPORTS];
	logic [8:0] rdat [block_ram_pkg::NPORTS];

	assign rdat[0] = link.port_a_read_data;
	assign rdat[1] = link.port_b_read_data;

	genvar p;
	generate
		for (p = 0; p < block_ram_pkg::NPORTS; p++) begin : g_port
			localparam logic [7:0] CFG_OFF = (p == 0) ? block_ram_pkg::REG_CFG_A : block_ram_pkg::REG_CFG_B;
			localparam logic [7:0] ACC_OFF = (p == 0) ? block_ram_pkg::REG_ACC_A : block_ram_pkg::REG_ACC_B;
			logic cfg_hit;
			logic acc_hit;
			logic [1:0] nxt_aspect;
			logic [11:0] used;

			assign cfg_hit = commit & (ph_addr_ff == CFG_OFF);
			assign acc_hit = commit & (ph_addr_ff == ACC_OFF);
			// aspect may change only while the port is disabled
			assign nxt_aspect = en_n_ff[p] ? hwdata[block_ram_pkg::CFG_ASPECT_LSB +: 2] : aspect_ff[p];
			// location bits above the used range are driven to zero
			assign used = (aspect_ff[p] == block_ram_pkg::ASPECT_X1) ? block_ram_pkg::USED_X1 :
				(aspect_ff[p] == block_ram_pkg::ASPECT_X2) ? block_ram_pkg::USED_X2 :
				(aspect_ff[p] == block_ram_pkg::ASPECT_X4) ? block_ram_pkg::USED_X4 : block_ram_pkg::USED_X9;
			assign cfg_view[p] = {27'h0000000, ~en_n_ff[p], wmode_ff[p], pipe_ff[p], aspect_ff[p]};
			assign acc_view[p] = {10'h000, ~write_n_ff[p], wdat_ff[p], loc_ff[p]};

			// an access write fires one port edge pulse in the next cycle
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					aspect_ff[p] <= block_ram_pkg::ASPECT_X1;
					pipe_ff[p] <= 1'b0;
					wmode_ff[p] <= 1'b0;
					en_n_ff[p] <= 1'b1;
					write_n_ff[p] <= 1'b1;
					pulse_ff[p] <= 1'b0;
					loc_ff[p] <= 12'h000;
					wdat_ff[p] <= 9'h000;
				end else begin
					pulse_ff[p] <= acc_hit;
					if (cfg_hit) begin
						aspect_ff[p] <= nxt_aspect;
						pipe_ff[p] <= hwdata[block_ram_pkg::CFG_PIPE_BIT];
						wmode_ff[p] <= hwdata[block_ram_pkg::CFG_WMODE_BIT];
						en_n_ff[p] <= ~hwdata[block_ram_pkg::CFG_EN_BIT];
					end
					if (acc_hit) begin
						loc_ff[p] <= hwdata[block_ram_pkg::ACC_LOC_LSB +: 12] & used;
						wdat_ff[p] <= hwdata[block_ram_pkg::ACC_DATA_LSB +: 9];
						write_n_ff[p] <= ~hwdata[block_ram_pkg::ACC_WRITE_BIT];
					end
				end
			end
		end
	endgenerate

	// register read selection; unmapped offsets read zero
	assign read_mux = (ph_addr_ff == block_ram_pkg::REG_CTRL) ? {31'h00000000, ~ram_reset_n_ff} :
		(ph_addr_ff == block_ram_pkg::REG_CFG_A) ? cfg_view[0] :
		(ph_addr_ff == block_ram_pkg::REG_CFG_B) ? cfg_view[1] :
		(ph_addr_ff == block_ram_pkg::REG_ACC_A) ? acc_view[0] :
		(ph_addr_ff == block_ram_pkg::REG_ACC_B) ? acc_view[1] :
		(ph_addr_ff == block_ram_pkg::REG_RD_A) ? {23'h000000, rdat[0]} :
		(ph_addr_ff == block_ram_pkg::REG_RD_B) ? {23'h000000, rdat[1]} : 32'h00000000;

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------

	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign link.ram_reset_n = ram_reset_n_ff;
	assign link.port_a_aspect_select = aspect_ff[0];
	assign link.port_a_enable_n = en_n_ff[0];
	assign link.port_a_write_n = write_n_ff[0];
	assign link.port_a_clock = pulse_ff[0];
	assign link.port_a_output_register_select = pipe_ff[0];
	assign link.port_a_write_output_mode = wmode_ff[0];
	assign link.port_a_location = loc_ff[0];
	assign link.port_a_write_data = wdat_ff[0];
	assign link.port_b_aspect_select = aspect_ff[1];
	assign link.port_b_enable_n = en_n_ff[1];
	assign link.port_b_write_n = write_n_ff[1];
	assign link.port_b_clock = pulse_ff[1];
	assign link.port_b_output_register_select = pipe_ff[1];
	assign link.port_b_write_output_mode = wmode_ff[1];
	assign link.port_b_location = loc_ff[1];
	assign link.port_b_write_data = wdat_ff[1];

endmodule // ram_fabric_controller

// >>> block_ram_pkg.sv
// Functional notes
// - aspect select 00/01/10/11 gives 4kx1..512x9
// - fabric keeps aspect select static while running
// - disabled port holds its read output
// - write-enable low writes, high reads
// - accesses timed by each port clock
// - pipeline select adds one cycle latency
// - write mode: hold last read or pass-through
// - write mode ignored on reads
// - reset zeroes outputs, blocks access, clears holds
// - reset keeps memory array contents
// - 12-bit location for reads and writes
// - fabric grounds unused high location bits
// - little-endian lane placement
// - ninth bit undefined after 4-bit writes
// - used location bits depend on aspect
package block_ram_pkg;
	// ---------------------------------------------
	// array geometry
	// ---------------------------------------------
	localparam int NPORTS = 2;
	localparam int LOC_W = 12;
	localparam int DATA_W = 9;
	localparam int WORD_W = 9;
	localparam int WORDS = 512;
	localparam int SHIFT_W = 4;
	// ---------------------------------------------
	// aspect codes, lane masks, used location bits
	// ---------------------------------------------
	localparam logic [1:0] ASPECT_X1 = 2'h0;
	localparam logic [1:0] ASPECT_X2 = 2'h1;
	localparam logic [1:0] ASPECT_X4 = 2'h2;
	localparam logic [1:0] ASPECT_X9 = 2'h3;
	localparam logic [8:0] LANE_X1 = 9'h001;
	localparam logic [8:0] LANE_X2 = 9'h003;
	localparam logic [8:0] LANE_X4 = 9'h00f;
	localparam logic [8:0] LANE_X9 = 9'h1ff;
	localparam logic [11:0] USED_X1 = 12'hfff;
	localparam logic [11:0] USED_X2 = 12'h7ff;
	localparam logic [11:0] USED_X4 = 12'h3ff;
	localparam logic [11:0] USED_X9 = 12'h1ff;
	// ---------------------------------------------
	// controller register map (byte offsets)
	// ---------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CFG_A = 8'h04;
	localparam logic [7:0] REG_CFG_B = 8'h08;
	localparam logic [7:0] REG_ACC_A = 8'h0c;
	localparam logic [7:0] REG_ACC_B = 8'h10;
	localparam logic [7:0] REG_RD_A = 8'h14;
	localparam logic [7:0] REG_RD_B = 8'h18;
	localparam int CTRL_RST_BIT = 0;
	localparam int CFG_ASPECT_LSB = 0;
	localparam int CFG_PIPE_BIT = 2;
	localparam int CFG_WMODE_BIT = 3;
	localparam int CFG_EN_BIT = 4;
	localparam int ACC_LOC_LSB = 0;
	localparam int ACC_DATA_LSB = 12;
	localparam int ACC_WRITE_BIT = 21;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// >>> block_ram_if.sv
`timescale 1ns/1ps
interface block_ram_if;
	logic ram_reset_n;
	logic [1:0] port_a_aspect_select;
	logic port_a_enable_n;
	logic port_a_write_n;
	logic port_a_clock;
	logic port_a_output_register_select;
	logic port_a_write_output_mode;
	logic [11:0] port_a_location;
	logic [8:0] port_a_write_data;
	logic [8:0] port_a_read_data;
	logic [1:0] port_b_aspect_select;
	logic port_b_enable_n;
	logic port_b_write_n;
	logic port_b_clock;
	logic port_b_output_register_select;
	logic port_b_write_output_mode;
	logic [11:0] port_b_location;
	logic [8:0] port_b_write_data;
	logic [8:0] port_b_read_data;

	// the ram end
	modport ram (
		input ram_reset_n,
		input port_a_aspect_select, port_a_enable_n, port_a_write_n, port_a_clock,
		input port_a_output_register_select, port_a_write_output_mode,
		input port_a_location, port_a_write_data,
		output port_a_read_data,
		input port_b_aspect_select, port_b_enable_n, port_b_write_n, port_b_clock,
		input port_b_output_register_select, port_b_write_output_mode,
		input port_b_location, port_b_write_data,
		output port_b_read_data
	);

	// the fabric end that drives both ports
	modport fabric (
		output ram_reset_n,
		output port_a_aspect_select, port_a_enable_n, port_a_write_n, port_a_clock,
		output port_a_output_register_select, port_a_write_output_mode,
		output port_a_location, port_a_write_data,
		input port_a_read_data,
		output port_b_aspect_select, port_b_enable_n, port_b_write_n, port_b_clock,
		output port_b_output_register_select, port_b_write_output_mode,
		output port_b_location, port_b_write_data,
		input port_b_read_data
	);
endinterface // block_ram_if

// >>> dual_port_block_ram.sv
`timescale 1ns/1ps
module dual_port_block_ram (
	input wire logic hclk,
	input wire logic hresetn,
	block_ram_if.ram link,
	output logic write_collision
);

	// ---------------------------------------------
	// lane geometry helpers
	// ---------------------------------------------

	// width mask of one datum for an aspect code
	function automatic logic [8:0] lane_mask_of(input logic [1:0] asp);
		logic [8:0] m;
		m = block_ram_pkg::LANE_X9;
		unique case (asp)
			block_ram_pkg::ASPECT_X1: m = block_ram_pkg::LANE_X1;
			block_ram_pkg::ASPECT_X2: m = block_ram_pkg::LANE_X2;
			block_ram_pkg::ASPECT_X4: m = block_ram_pkg::LANE_X4;
			block_ram_pkg::ASPECT_X9: m = block_ram_pkg::LANE_X9;
		endcase
		return m;
	endfunction

	// bit offset inside a word; the lowest location sits in the low bits
	function automatic logic [3:0] lane_shift_of(input logic [1:0] asp, input logic [11:0] loc);
		logic [3:0] s;
		s = 4'h0;
		unique case (asp)
			block_ram_pkg::ASPECT_X1: s = {1'b0, loc[2:0]};
			block_ram_pkg::ASPECT_X2: s = {1'b0, loc[1:0], 1'b0};
			block_ram_pkg::ASPECT_X4: s = {1'b0, loc[0], 2'b00};
			block_ram_pkg::ASPECT_X9: s = 4'h0;
		endcase
		return s;
	endfunction

	// word index; upper location bits beyond the used range are ignored
	function automatic logic [8:0] word_of(input logic [1:0] asp, input logic [11:0] loc);
		logic [8:0] w;
		w = loc[8:0];
		unique case (asp)
			block_ram_pkg::ASPECT_X1: w = loc[11:3];
			block_ram_pkg::ASPECT_X2: w = loc[10:2];
			block_ram_pkg::ASPECT_X4: w = loc[9:1];
			block_ram_pkg::ASPECT_X9: w = loc[8:0];
		endcase
		return w;
	endfunction

	// ---------------------------------------------
	// port bundling
	// ---------------------------------------------

	logic [1:0] aspect [block_ram_pkg::NPORTS];
	logic enable_n [block_ram_pkg::NPORTS];
	logic write_n [block_ram_pkg::NPORTS];
	logic edge_pulse [block_ram_pkg::NPORTS];
	logic pipe_sel [block_ram_pkg::NPORTS];
	logic wmode_sel [block_ram_pkg::NPORTS];
	logic [11:0] location [block_ram_pkg::NPORTS];
	logic [8:0] wr_data [block_ram_pkg::NPORTS];

	// the two ports are folded into arrays so one loop serves both
	assign aspect[0] = link.port_a_aspect_select;
	assign aspect[1] = link.port_b_aspect_select;
	assign enable_n[0] = link.port_a_enable_n;
	assign enable_n[1] = link.port_b_enable_n;
	assign write_n[0] = link.port_a_write_n;
	assign write_n[1] = link.port_b_write_n;
	assign edge_pulse[0] = link.port_a_clock;
	assign edge_pulse[1] = link.port_b_clock;
	assign pipe_sel[0] = link.port_a_output_register_select;
	assign pipe_sel[1] = link.port_b_output_register_select;
	assign wmode_sel[0] = link.port_a_write_output_mode;
	assign wmode_sel[1] = link.port_b_write_output_mode;
	assign location[0] = link.port_a_location;
	assign location[1] = link.port_b_location;
	assign wr_data[0] = link.port_a_write_data;
	assign wr_data[1] = link.port_b_write_data;

	// ---------------------------------------------
	// storage
	// ---------------------------------------------

	// no reset on the array: contents survive both resets
	logic [8:0] mem_ff [block_ram_pkg::WORDS];

	logic [8:0] word_idx [block_ram_pkg::NPORTS];
	logic [8:0] bit_mask [block_ram_pkg::NPORTS];
	logic [8:0] wr_aligned [block_ram_pkg::NPORTS];
	logic do_write [block_ram_pkg::NPORTS];
	logic [8:0] stage_ff [block_ram_pkg::NPORTS];
	logic [8:0] out_ff [block_ram_pkg::NPORTS];

	// ---------------------------------------------
	// per-port access and output path
	// ---------------------------------------------

	genvar p;
	generate
		for (p = 0; p < block_ram_pkg::NPORTS; p++) begin : g_port
			logic [8:0] lane;
			logic [3:0] shift;
			logic access;
			logic do_read;
			logic [8:0] rd_value;
			logic [8:0] hold_value;
			logic [8:0] nxt_value;

			// geometry of this access
			assign lane = lane_mask_of(aspect[p]);
			assign shift = lane_shift_of(aspect[p], location[p]);
			assign word_idx[p] = word_of(aspect[p], location[p]);

			// an access needs the port edge, the enable and both resets released
			assign access = edge_pulse[p] & ~enable_n[p] & link.ram_reset_n & hresetn;
			assign do_write[p] = access & ~write_n[p];
			assign do_read = access & write_n[p];

			// place the datum in its lane; untouched lanes keep their bits
			assign bit_mask[p] = lane << shift;
			assign wr_aligned[p] = (wr_data[p] & lane) << shift;

			// read: in 9-bit mode bit 8 is whatever was last stored there,
			// so after narrow writes it carries no defined meaning
			assign rd_value = (mem_ff[word_idx[p]] >> shift) & lane;

			// the last read value seen by the user, at either latency
			assign hold_value = pipe_sel[p] ? stage_ff[p] : out_ff[p];

			// reads always show data; writes follow the write-mode select
			assign nxt_value = do_read ? rd_value :
				(wmode_sel[p] ? (wr_data[p] & lane) : hold_value);

			// output registers; a disabled port simply keeps them
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					stage_ff[p] <= 9'h000;
					out_ff[p] <= 9'h000;
				end else if (!link.ram_reset_n) begin
					stage_ff[p] <= 9'h000;
					out_ff[p] <= 9'h000;
				end else if (access) begin
					stage_ff[p] <= nxt_value;
					out_ff[p] <= pipe_sel[p] ? stage_ff[p] : nxt_value;
				end
			end
		end
	endgenerate

	// ---------------------------------------------
	// array write, both ports
	// ---------------------------------------------

	logic same_word;
	logic [8:0] a_merge;
	logic [8:0] b_base;
	logic [8:0] b_merge;

	// same-word writes merge lanes; where lanes overlap port b wins,
	// and port b merges onto port a's result, so both writes are kept when lanes differ
	assign same_word = do_write[0] & do_write[1] & (word_idx[0] == word_idx[1]);
	assign a_merge = (mem_ff[word_idx[0]] & ~bit_mask[0]) | wr_aligned[0];
	assign b_base = same_word ? a_merge : mem_ff[word_idx[1]];
	assign b_merge = (b_base & ~bit_mask[1]) | wr_aligned[1];

	// plain clocked write with no reset term
	always_ff @(posedge hclk) begin
		if (do_write[0]) begin
			mem_ff[word_idx[0]] <= a_merge;
		end
		if (do_write[1]) begin
			mem_ff[word_idx[1]] <= b_merge;
		end
	end

	// ---------------------------------------------
	// collision flag and outputs
	// ---------------------------------------------

	logic collision_ff;
	logic nxt_collision;

	// one-cycle flag when both ports wrote the same bits in one edge
	assign nxt_collision = same_word & (|(bit_mask[0] & bit_mask[1]));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			collision_ff <= 1'b0;
		end else begin
			collision_ff <= nxt_collision;
		end
	end

	assign write_collision = collision_ff;
	assign link.port_a_read_data = out_ff[0];
	assign link.port_b_read_data = out_ff[1];

endmodule // dual_port_block_ram

// >>> block_ram_properties.sv
`timescale 1ns/1ps
module block_ram_properties (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ram_reset_n,
	input wire logic [1:0] port_a_aspect_select,
	input wire logic port_a_enable_n,
	input wire logic port_a_write_n,
	input wire logic port_a_clock,
	input wire logic port_a_output_register_select,
	input wire logic port_a_write_output_mode,
	input wire logic [11:0] port_a_location,
	input wire logic [8:0] port_a_write_data,
	input wire logic [8:0] port_a_read_data,
	input wire logic [1:0] port_b_aspect_select,
	input wire logic port_b_enable_n,
	input wire logic port_b_clock,
	input wire logic [11:0] port_b_location,
	input wire logic [8:0] port_b_read_data
);
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// data lanes that a port of the given aspect drives
	function automatic logic [8:0] lane(input logic [1:0] s);
		return (s == block_ram_pkg::ASPECT_X1) ? block_ram_pkg::LANE_X1 :
			(s == block_ram_pkg::ASPECT_X2) ? block_ram_pkg::LANE_X2 :
			(s == block_ram_pkg::ASPECT_X4) ? block_ram_pkg::LANE_X4 : block_ram_pkg::LANE_X9;
	endfunction

	// location bits that are in use for the given aspect
	function automatic logic [11:0] used(input logic [1:0] s);
		return (s == block_ram_pkg::ASPECT_X1) ? block_ram_pkg::USED_X1 :
			(s == block_ram_pkg::ASPECT_X2) ? block_ram_pkg::USED_X2 :
			(s == block_ram_pkg::ASPECT_X4) ? block_ram_pkg::USED_X4 : block_ram_pkg::USED_X9;
	endfunction

	// an edge at which port a really acts
	wire logic taken_a = port_a_clock && !port_a_enable_n && ram_reset_n;

	// ---------------------------------------------
	// properties
	// ---------------------------------------------
	a_idle_output_holds: assert property (ram_reset_n && (!port_a_clock || port_a_enable_n) |=> $stable(port_a_read_data))
		else $error("port a output moved without an access");
	a_b_idle_holds: assert property (ram_reset_n && (!port_b_clock || port_b_enable_n) |=> $stable(port_b_read_data))
		else $error("port b output moved without an access");
	a_reset_clears_outputs: assert property (!ram_reset_n |=> port_a_read_data == 9'h000 && port_b_read_data == 9'h000)
		else $error("outputs not zero under ram reset");
	a_pass_through_write: assert property (taken_a && !port_a_write_n && port_a_write_output_mode
		&& !port_a_output_register_select |=> port_a_read_data == ($past(port_a_write_data) & lane(port_a_aspect_select)))
		else $error("write data not passed to output");
	a_write_keeps_output: assert property (taken_a && !port_a_write_n && !port_a_write_output_mode
		&& !port_a_output_register_select |=> $stable(port_a_read_data))
		else $error("output changed on a holding write");
	a_read_lanes_low: assert property (taken_a && !port_a_output_register_select
		|=> (port_a_read_data & ~lane(port_a_aspect_select)) == 9'h000)
		else $error("narrow output uses upper bits");
	a_location_masked_a: assert property (port_a_clock |-> (port_a_location & ~used(port_a_aspect_select)) == 12'h000)
		else $error("port a unused location bits not zero");
	a_location_masked_b: assert property (port_b_clock |-> (port_b_location & ~used(port_b_aspect_select)) == 12'h000)
		else $error("port b unused location bits not zero");
	a_aspect_stays_static: assert property (!port_a_enable_n && !$past(port_a_enable_n) |-> $stable(port_a_aspect_select))
		else $error("aspect changed while port enabled");
endmodule // block_ram_properties

// >>> test_dual_port_block_ram.sv
`timescale 1ns/1ps
module test_dual_port_block_ram;
	// ---------------------------------------------
	// bus, clock and bookkeeping
	// ---------------------------------------------
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	wire logic hready;
	wire logic hresp;
	wire logic [31:0] hrdata;
	wire logic write_collision;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;
	int w[4] = '{1, 2, 4, 9};
	logic [8:0] ln;
	logic [11:0] loc;

	block_ram_if link ();
	dual_port_block_ram u_dual_port_block_ram (.hclk(hclk), .hresetn(hresetn), .link(link.ram),
		.write_collision(write_collision));
	ram_fabric_controller u_ram_fabric_controller (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link(link.fabric));
	block_ram_properties u_block_ram_properties (.hclk(hclk), .hresetn(hresetn), .ram_reset_n(link.ram_reset_n),
		.port_a_aspect_select(link.port_a_aspect_select), .port_a_enable_n(link.port_a_enable_n),
		.port_a_write_n(link.port_a_write_n), .port_a_clock(link.port_a_clock),
		.port_a_output_register_select(link.port_a_output_register_select),
		.port_a_write_output_mode(link.port_a_write_output_mode), .port_a_location(link.port_a_location),
		.port_a_write_data(link.port_a_write_data), .port_a_read_data(link.port_a_read_data),
		.port_b_aspect_select(link.port_b_aspect_select), .port_b_enable_n(link.port_b_enable_n),
		.port_b_clock(link.port_b_clock), .port_b_location(link.port_b_location),
		.port_b_read_data(link.port_b_read_data));

	// 100 MHz clock
	initial begin
		forever #5 hclk = ~hclk;
	end

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge hclk) begin
		cycles <= cycles + 1;
		// the controller never pulses both ports in one cycle, so a collision or an error response is a fault
		if (hresetn && (write_collision !== 1'b0 || hresp !== 1'b0)) begin
			n_mismatch++;
			$display("unexpected collision or response expected 0 seen %b %b", write_collision, hresp);
		end
		if (cycles == 5000) begin
			n_mismatch++;
			summarize();
		end
	end

	// ---------------------------------------------
	// bus tasks
	// ---------------------------------------------
	// one single transfer; both phases wait on hready, data taken at the closing edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		tests_run++;
		if (q !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, q);
			n_mismatch++;
		end
	endtask

	// fields: aspect, pipeline, write mode, enable
	task automatic cfg(input logic p, input logic [1:0] s, input logic pi, input logic wm, input logic en);
		wr(p ? block_ram_pkg::REG_CFG_B : block_ram_pkg::REG_CFG_A, {27'h000_0000, en, wm, pi, s});
	endtask

	// one port access: location, data, write flag
	task automatic acc(input logic p, input logic [11:0] l, input logic [8:0] d, input logic wrt);
		wr(p ? block_ram_pkg::REG_ACC_B : block_ram_pkg::REG_ACC_A, {10'h000, wrt, d, l});
	endtask

	task automatic summarize;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("rd_a after reset", block_ram_pkg::REG_RD_A, 32'h0000_0000);
		chk("rd_b after reset", block_ram_pkg::REG_RD_B, 32'h0000_0000);
		chk("unmapped offset", 8'h40, 32'h0000_0000);
		// holding write leaves the old output, the datum lands in the array
		cfg(1'b0, block_ram_pkg::ASPECT_X9, 1'b0, 1'b0, 1'b1);
		acc(1'b0, 12'h005, 9'h1a5, 1'b1);
		chk("output on holding write", block_ram_pkg::REG_RD_A, 32'h0000_0000);
		acc(1'b0, 12'h005, 9'h000, 1'b0);
		chk("x9 read back", block_ram_pkg::REG_RD_A, 32'h0000_01a5);
		// every aspect on port b, checked word-wide through port a; upper location bits set on purpose
		for (int s = 0; s < 4; s++) begin
			ln = 9'((1 << w[s]) - 1);
			loc = (s == 3) ? 12'h802 : ((12'h002 << (3 - s)) | 12'h001 | ((s > 0) ? 12'h800 : 12'h000));
			acc(1'b0, 12'h002, 9'h000, 1'b1);
			cfg(1'b1, 2'(s), 1'b0, 1'b1, 1'b0);
			cfg(1'b1, 2'(s), 1'b0, 1'b1, 1'b1);
			acc(1'b1, loc, ln, 1'b1);
			chk("pass through write", block_ram_pkg::REG_RD_B, {23'h00_0000, ln});
			acc(1'b0, 12'h002, 9'h000, 1'b0);
			chk("lane placement", block_ram_pkg::REG_RD_A, (s == 3) ? {23'h0, ln} : {23'h0, ln} << w[s]);
			acc(1'b1, loc, 9'h000, 1'b0);
			chk("read with pass mode", block_ram_pkg::REG_RD_B, {23'h00_0000, ln});
		end
		// narrow pass-through on port a; aspect only moves while the port is disabled
		cfg(1'b0, block_ram_pkg::ASPECT_X1, 1'b0, 1'b1, 1'b0);
		cfg(1'b0, block_ram_pkg::ASPECT_X1, 1'b0, 1'b1, 1'b1);
		acc(1'b0, 12'h038, 9'h1ff, 1'b1);
		chk("narrow pass through", block_ram_pkg::REG_RD_A, 32'h0000_0001);
		acc(1'b0, 12'h029, 9'h000, 1'b0);
		chk("narrow read of word", block_ram_pkg::REG_RD_A, 32'h0000_0000);
		acc(1'b0, 12'h038, 9'h000, 1'b0);
		chk("narrow write landed", block_ram_pkg::REG_RD_A, 32'h0000_0001);
		cfg(1'b0, block_ram_pkg::ASPECT_X1, 1'b0, 1'b0, 1'b0);
		// pipelined reads show the previous access
		cfg(1'b0, block_ram_pkg::ASPECT_X9, 1'b1, 1'b0, 1'b1);
		acc(1'b0, 12'h005, 9'h000, 1'b0);
		acc(1'b0, 12'h002, 9'h000, 1'b0);
		chk("pipeline lag one", block_ram_pkg::REG_RD_A, 32'h0000_01a5);
		acc(1'b0, 12'h005, 9'h000, 1'b0);
		chk("pipeline lag two", block_ram_pkg::REG_RD_A, 32'h0000_01ff);
		// disabled port neither writes nor moves its output
		cfg(1'b0, block_ram_pkg::ASPECT_X9, 1'b0, 1'b0, 1'b0);
		acc(1'b0, 12'h005, 9'h000, 1'b1);
		chk("disabled output held", block_ram_pkg::REG_RD_A, 32'h0000_01ff);
		cfg(1'b0, block_ram_pkg::ASPECT_X9, 1'b0, 1'b0, 1'b1);
		acc(1'b0, 12'h005, 9'h000, 1'b0);
		chk("disabled write refused", block_ram_pkg::REG_RD_A, 32'h0000_01a5);
		// ram reset clears outputs and blocks access but keeps the array
		wr(block_ram_pkg::REG_CTRL, 32'h0000_0001);
		chk("output under ram reset", block_ram_pkg::REG_RD_A, 32'h0000_0000);
		acc(1'b0, 12'h002, 9'h000, 1'b1);
		chk("access blocked in reset", block_ram_pkg::REG_RD_A, 32'h0000_0000);
		wr(block_ram_pkg::REG_CTRL, 32'h0000_0000);
		acc(1'b0, 12'h002, 9'h000, 1'b0);
		chk("contents kept", block_ram_pkg::REG_RD_A, 32'h0000_01ff);
		summarize();
	end
endmodule // test_dual_port_block_ram
